// *** hdl/i2cs_pkg.sv ***
// constants and state codes for the two-wire slave block
package i2cs_pkg;
  // control register layout
  localparam int          CTL_W        = 16;
  localparam int          CTL_EN       = 15;
  localparam int          CTL_REL      = 12;
  localparam int          CTL_WIDE     = 10;
  localparam int          CTL_STRETCH  = 6;
  localparam logic [15:0] CTL_RESET    = 16'h1000;
  // status register layout, bits below STA_RW_LO are hardware owned
  localparam int          STA_W        = 16;
  localparam int          STA_RW_LO    = 6;
  localparam int          STA_OV       = 6;
  localparam int          STA_TXFULL   = 0;
  localparam int          STA_RXFULL   = 1;
  localparam int          STA_DIR      = 2;
  localparam int          STA_FWM      = 3;
  localparam int          STA_ADDRD    = 4;
  localparam int          STA_DATA     = 5;
  localparam logic [9:0]  STA_RW_RESET = 10'h000;
  // address handling
  localparam int          ADDR_W       = 10;
  localparam logic [4:0]  TEN_HDR      = 5'h1e;
  // byte framing on the wire
  localparam logic [3:0]  BIT_LAST     = 4'h8;
  localparam logic [3:0]  BIT_ACK      = 4'h9;
  localparam logic [3:0]  BIT_ZERO     = 4'h0;
  localparam logic [3:0]  BIT_ONE      = 4'h1;
  // bit rate generator reload width
  localparam int          BRG_W        = 16;
  localparam logic [15:0] BRG_RESET    = 16'h0000;
  // slave sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_ADDR2 = 6'b000100,
    ST_RX    = 6'b001000,
    ST_TX    = 6'b010000,
    ST_WAIT  = 6'b100000
  } i2cs_state_t;
endpackage

// *** hdl/i2cs_slave.sv ***
// two-wire bus slave: address match, receive and transmit paths
`timescale 1ns/1ps

module i2cs_slave (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_reset,
  input  wire logic                      i_scl,
  input  wire logic                      i_sda,
  output logic                           o_scl_out,
  output logic                           o_scl_oe,
  output logic                           o_sda_out,
  output logic                           o_sda_oe,
  input  wire logic                      i_control_wr,
  input  wire logic [i2cs_pkg::CTL_W-1:0] i_control_wdata,
  output logic      [i2cs_pkg::CTL_W-1:0] o_control_register,
  input  wire logic                      i_status_wr,
  input  wire logic [i2cs_pkg::STA_W-1:0] i_status_wdata,
  output logic      [i2cs_pkg::STA_W-1:0] o_status_register,
  input  wire logic [i2cs_pkg::ADDR_W-1:0] i_own_address_register,
  input  wire logic                      i_tx_write,
  input  wire logic [7:0]                i_tx_data,
  input  wire logic                      i_rx_read,
  output logic      [7:0]                o_receive_buffer,
  input  wire logic                      i_baud_wr,
  input  wire logic [i2cs_pkg::BRG_W-1:0] i_baud_wdata,
  output logic                           o_baud_tick,
  output logic                           o_slave_event_flag
);
  import i2cs_pkg::*;

  i2cs_state_t      state;
  logic [1:0]       scl_sync;
  logic [1:0]       sda_sync;
  logic             scl_p;
  logic             sda_p;
  logic [3:0]       bitcnt;
  logic [7:0]       rx_shift_register;
  logic [7:0]       transmit_register;
  logic [7:0]       tx_shift;
  logic             tx_on;
  logic             need_load;
  logic             ack_drive;
  logic             ev_pend;
  logic             master_ack;
  logic             dir;
  logic             data_last;
  logic             full_wide_match_flag;
  logic             receive_buffer_full;
  logic             transmit_buffer_full;
  logic             clock_release_bit;
  logic [CTL_W-1:0] control_register;
  logic [9:0]       status_rw;
  logic [BRG_W-1:0] baud_reload_register;
  logic [BRG_W-1:0] baud_cnt;
  logic             module_enable_bit;
  logic             address_width_select;
  logic             stretch_enable;
  logic             receive_overflow_flag;
  logic             scl_s;
  logic             sda_s;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             busy;
  logic             byte_fall;
  logic             ack_fall;
  logic             hdr_ok;
  logic             byte_ok;
  logic             tx_load;
  logic             stretch_now;

  assign module_enable_bit     = control_register[CTL_EN];
  assign address_width_select  = control_register[CTL_WIDE];
  assign stretch_enable        = control_register[CTL_STRETCH];
  assign receive_overflow_flag = status_rw[STA_OV-STA_RW_LO];

  // two flops on each pin before anything looks at it
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_p    <= 1'b1;
      sda_p    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_p    <= scl_sync[1];
      sda_p    <= sda_sync[1];
    end
  end

  // bus events seen through the synchronised pins
  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
  assign busy      = (state == ST_ADDR) | (state == ST_ADDR2) | (state == ST_RX)
                   | (state == ST_TX);
  assign byte_fall = scl_fall & busy & (bitcnt == BIT_LAST);
  assign ack_fall  = scl_fall & busy & (bitcnt == BIT_ACK);

  // byte verdicts, looked at on the eighth falling edge
  assign hdr_ok = (rx_shift_register[7:3] == TEN_HDR)
                & (rx_shift_register[2:1] == i_own_address_register[9:8]);
  always_comb begin
    byte_ok = 1'b0;
    case (state)
      ST_ADDR: begin
        if (address_width_select) begin
          // header with read only counts after a full match
          byte_ok = hdr_ok & (~rx_shift_register[0] | full_wide_match_flag);
        end else begin
          byte_ok = rx_shift_register[7:1] == i_own_address_register[6:0];
        end
      end
      ST_ADDR2: byte_ok = rx_shift_register == i_own_address_register[7:0];
      ST_RX:    byte_ok = ~receive_buffer_full & ~receive_overflow_flag;
      default:  byte_ok = 1'b0;
    endcase
  end

  // transmit empty at the ninth clock stretches unless the master nacked, receive full only with enable
  assign stretch_now = ack_fall & (((state == ST_TX) & ~sda_s & ~transmit_buffer_full)
                     | ((state == ST_ADDR) & dir & ~transmit_buffer_full)
                     | ((state == ST_RX) & stretch_enable & receive_buffer_full));
  assign tx_load     = need_load & transmit_buffer_full & (state == ST_TX);

  // sequencer: idle, address bytes, receive, transmit, wait for stop
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state <= ST_IDLE;
    end else if (!module_enable_bit || stop_det) begin
      state <= ST_IDLE;
    end else if (start_det) begin
      state <= ST_ADDR;
    end else if (byte_fall) begin
      case (state)
        ST_ADDR: begin
          if (!byte_ok) begin
            state <= ST_WAIT;
          end else if (rx_shift_register[0]) begin
            state <= ST_ADDR; // becomes transmit after the ack clock
          end else if (address_width_select) begin
            state <= ST_ADDR2;
          end else begin
            state <= ST_RX;
          end
        end
        ST_ADDR2: state <= byte_ok ? ST_RX : ST_WAIT;
        default:  state <= state;
      endcase
    end else if (ack_fall) begin
      if (state == ST_ADDR) begin
        state <= ST_TX;
      end else if (state == ST_TX && sda_s) begin
        state <= ST_WAIT; // master declined more data
      end
    end
  end

  // bit counter and receive shifting on rising clock edges
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bitcnt            <= BIT_ZERO;
      rx_shift_register <= 8'h00;
      master_ack        <= 1'b0;
    end else if (start_det || !busy) begin
      bitcnt <= BIT_ZERO;
    end else if (ack_fall) begin
      bitcnt <= BIT_ZERO;
    end else if (scl_rise) begin
      bitcnt <= bitcnt + BIT_ONE;
      if (bitcnt < BIT_LAST) begin
        rx_shift_register <= {rx_shift_register[6:0], sda_s};
      end else begin
        master_ack <= ~sda_s;
      end
    end
  end

  // acknowledge drive held from the eighth to the ninth falling edge
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ack_drive <= 1'b0;
      ev_pend   <= 1'b0;
    end else if (start_det || stop_det || ack_fall) begin
      ack_drive <= 1'b0;
      ev_pend   <= 1'b0;
    end else if (byte_fall) begin
      ack_drive <= byte_ok & (state != ST_TX);
      // receive and transmit bytes always raise the event
      ev_pend   <= byte_ok | (state == ST_RX) | (state == ST_TX);
    end
  end

  // slave event pulse on the ninth falling edge
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_slave_event_flag <= 1'b0;
    end else begin
      o_slave_event_flag <= ack_fall & ev_pend;
    end
  end

  // address outcome: direction and wide match status
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      dir                  <= 1'b0;
      full_wide_match_flag <= 1'b0;
      data_last            <= 1'b0;
    end else if (stop_det || !module_enable_bit) begin
      full_wide_match_flag <= 1'b0;
      data_last            <= 1'b0;
    end else if (byte_fall) begin
      data_last <= (state == ST_RX) | (state == ST_TX);
      if (state == ST_ADDR) begin
        if (byte_ok) begin
          dir <= rx_shift_register[0];
        end
        // partial match or failure both clear the flag; header read keeps it
        if (!(byte_ok && rx_shift_register[0] && address_width_select)) begin
          full_wide_match_flag <= 1'b0;
        end
      end else if (state == ST_ADDR2) begin
        full_wide_match_flag <= byte_ok;
      end
    end
  end

  // receive buffer; loaded only from a completed data byte
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_receive_buffer    <= 8'h00;
      receive_buffer_full <= 1'b0;
    end else if (byte_fall && state == ST_RX && !receive_buffer_full) begin
      o_receive_buffer    <= rx_shift_register;
      receive_buffer_full <= 1'b1; // load beats a same-cycle read
    end else if (i_rx_read) begin
      receive_buffer_full <= 1'b0;
    end
  end

  // status upper bits are software owned; overflow set beats the write
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      status_rw <= STA_RW_RESET;
    end else begin
      if (i_status_wr) begin
        status_rw <= i_status_wdata[STA_W-1:STA_RW_LO];
      end
      if (byte_fall && state == ST_RX && receive_buffer_full) begin
        status_rw[STA_OV-STA_RW_LO] <= 1'b1;
      end
    end
  end

  // transmit register is single buffered: write, then moved to the shifter
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      transmit_register    <= 8'h00;
      transmit_buffer_full <= 1'b0;
    end else if (i_tx_write) begin
      transmit_register    <= i_tx_data;
      transmit_buffer_full <= 1'b1; // write wins over a same-cycle load
    end else if (tx_load) begin
      transmit_buffer_full <= 1'b0;
    end
  end

  // transmit shifter, data changes only while the clock is low
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tx_shift  <= 8'h00;
      tx_on     <= 1'b0;
      need_load <= 1'b0;
    end else if (start_det || stop_det || !busy) begin
      tx_on     <= 1'b0;
      need_load <= 1'b0;
    end else if (ack_fall && (state == ST_ADDR || (state == ST_TX && !sda_s))) begin
      need_load <= 1'b1;
    end else if (tx_load) begin
      tx_shift  <= transmit_register;
      tx_on     <= 1'b1;
      need_load <= 1'b0;
    end else if (scl_fall && tx_on) begin
      if (bitcnt == BIT_LAST) begin
        tx_on <= 1'b0; // let the master drive its ack
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // control register; release bit also cleared by hardware when stretching
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      control_register  <= CTL_RESET;
      clock_release_bit <= CTL_RESET[CTL_REL];
    end else begin
      if (i_control_wr) begin
        control_register <= i_control_wdata;
      end
      if (i_control_wr && i_control_wdata[CTL_REL]) begin
        clock_release_bit <= 1'b1;
      end else if (stretch_now) begin
        clock_release_bit <= 1'b0;
      end else if (i_control_wr && stretch_enable) begin
        clock_release_bit <= 1'b0; // clearing only honoured with stretch enabled
      end
    end
  end

  // baud reload register and the generator it reloads
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      baud_reload_register <= BRG_RESET;
      baud_cnt             <= BRG_RESET;
      o_baud_tick          <= 1'b0;
    end else begin
      if (i_baud_wr) begin
        baud_reload_register <= i_baud_wdata;
      end
      o_baud_tick <= baud_cnt == BRG_RESET;
      if (baud_cnt == BRG_RESET) begin
        baud_cnt <= baud_reload_register;
      end else begin
        baud_cnt <= baud_cnt - BRG_W'(1);
      end
    end
  end

  // open-drain pins: only ever pull low
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe  = ~clock_release_bit & module_enable_bit;
  assign o_sda_oe  = ack_drive | (tx_on & ~tx_shift[7]);
  assign o_control_register = {control_register[CTL_W-1:CTL_REL+1], clock_release_bit,
                               control_register[CTL_REL-1:0]};
  assign o_status_register  = {status_rw, data_last, busy, full_wide_match_flag, dir,
                               receive_buffer_full, transmit_buffer_full};

  property p_sample;
    @(posedge i_sys_clk) disable iff (i_reset)
      scl_rise && busy && !start_det && bitcnt < BIT_LAST |=> rx_shift_register[0] == $past(sda_s);
  endproperty
  a_sample: assert property (p_sample) else $error("bit not sampled on rise");

  property p_addr7;
    @(posedge i_sys_clk) disable iff (i_reset)
      byte_fall && state == ST_ADDR && !address_width_select && !stop_det && !start_det
      && rx_shift_register[7:1] == i_own_address_register[6:0] |=> o_sda_oe;
  endproperty
  a_addr7: assert property (p_addr7) else $error("7-bit match not acked");

  property p_event;
    @(posedge i_sys_clk) disable iff (i_reset)
      ack_fall && ev_pend && !start_det && !stop_det |=> o_slave_event_flag ##1 !o_slave_event_flag;
  endproperty
  a_event: assert property (p_event) else $error("event pulse missing");

  property p_addr_keeps_rx;
    @(posedge i_sys_clk) disable iff (i_reset)
      byte_fall && state != ST_RX |=> $stable(o_receive_buffer);
  endproperty
  a_addr_keeps_rx: assert property (p_addr_keeps_rx) else $error("address touched buffer");

  property p_tx_hold;
    @(posedge i_sys_clk) disable iff (i_reset)
      ack_fall && state == ST_ADDR && dir && !transmit_buffer_full && !i_control_wr
      && module_enable_bit |=> o_scl_oe;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("clock not held for load");

  property p_full_nack;
    @(posedge i_sys_clk) disable iff (i_reset)
      byte_fall && state == ST_RX && receive_buffer_full && !start_det && !stop_det
      |=> !ack_drive && $stable(o_receive_buffer) && receive_overflow_flag;
  endproperty
  a_full_nack: assert property (p_full_nack) else $error("full buffer acked");

  property p_ov_nack;
    @(posedge i_sys_clk) disable iff (i_reset)
      byte_fall && state == ST_RX && !receive_buffer_full && receive_overflow_flag
      && !start_det && !stop_det |=> !ack_drive && receive_buffer_full;
  endproperty
  a_ov_nack: assert property (p_ov_nack) else $error("overflow byte mishandled");

  property p_wide2;
    @(posedge i_sys_clk) disable iff (i_reset)
      byte_fall && state == ST_ADDR2 && !stop_det && !start_det && module_enable_bit
      && rx_shift_register == i_own_address_register[7:0] |=> full_wide_match_flag && state == ST_RX;
  endproperty
  a_wide2: assert property (p_wide2) else $error("second byte match lost");

  property p_stop;
    @(posedge i_sys_clk) disable iff (i_reset)
      stop_det |=> state == ST_IDLE && !full_wide_match_flag ##1 !o_sda_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not idle");

endmodule

// *** testbench/i2cs_master_model.sv ***
// behavioural two-wire bus master driving open-drain clock and data
`timescale 1ns/1ps
module i2cs_master_model (
  input  wire logic i_sys_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_drive,
  output logic      o_sda_drive,
  output logic      o_stuck
);
  localparam int QTR = 4;
  // both lines released at time zero, bus idle high
  initial begin
    o_scl_drive = 1'b1;
    o_sda_drive = 1'b1;
    o_stuck     = 1'b0;
  end
  // quarter of the 160 ns bit period
  task automatic tq(input int n);
    repeat (n * QTR) @(posedge i_sys_clk);
  endtask
  // release clock, then wait out a slave stretch under a bound
  task automatic scl_up();
    int k;
    o_scl_drive <= 1'b1;
    for (k = 0; k < 5000 && i_scl !== 1'b1; k++) @(posedge i_sys_clk);
    if (k == 5000) o_stuck <= 1'b1;
  endtask
  // one bit: data moves only while clock is low
  task automatic bit_io(input logic b, output logic s);
    tq(1);
    o_sda_drive <= b;
    tq(1);
    scl_up();
    tq(1);
    s = i_sda;
    tq(1);
    o_scl_drive <= 1'b0;
  endtask
  // start or repeated start, no stop needed before it
  task automatic send_start();
    @(posedge i_sys_clk);
    o_sda_drive <= 1'b1;
    tq(1);
    scl_up();
    tq(2);
    o_sda_drive <= 1'b0;
    tq(2);
    o_scl_drive <= 1'b0;
    tq(1);
  endtask
  task automatic send_stop();
    @(posedge i_sys_clk);
    o_sda_drive <= 1'b0;
    tq(1);
    scl_up();
    tq(2);
    o_sda_drive <= 1'b1;
    tq(2);
  endtask
  // msb first, then sample the slave acknowledge
  task automatic write_byte(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, nack);
  endtask
  task automatic read_byte(input logic nk, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nk, s);
  endtask
endmodule

// *** testbench/i2cs_slave_test.sv ***
// self-checking bench for the two-wire slave against a master model
`timescale 1ns/1ps
module i2cs_slave_test;
  import i2cs_pkg::*;
  logic        i_sys_clk, i_reset, ctl_wr, sta_wr, tx_wr, rx_rd, baud_wr;
  logic [15:0] wdata, ctl_q, sta_q, v, old;
  logic [9:0]  own;
  logic [7:0]  tx_d, rx_q, rd, d, exp_buf;
  logic        scl_oe, sda_oe, tick, ev, m_scl, m_sda, stuck, a;
  logic        exp_rbf, exp_ov;
  logic [7:0]  txq[$];
  int          n_fail, samples_checked, n_ev, exp_ev, k;
  // open-drain wires: anyone pulling wins
  wire         scl = m_scl & ~scl_oe;
  wire         sda = m_sda & ~sda_oe;
  i2cs_slave u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
    .o_scl_out(), .o_scl_oe(scl_oe), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_control_wr(ctl_wr), .i_control_wdata(wdata), .o_control_register(ctl_q),
    .i_status_wr(sta_wr), .i_status_wdata(wdata), .o_status_register(sta_q),
    .i_own_address_register(own), .i_tx_write(tx_wr), .i_tx_data(tx_d),
    .i_rx_read(rx_rd), .o_receive_buffer(rx_q), .i_baud_wr(baud_wr),
    .i_baud_wdata(wdata), .o_baud_tick(tick), .o_slave_event_flag(ev));
  i2cs_master_model u_m (.i_sys_clk(i_sys_clk), .i_scl(scl), .i_sda(sda),
    .o_scl_drive(m_scl), .o_sda_drive(m_sda), .o_stuck(stuck));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // event pulses are one cycle, so count every clock
  always @(posedge i_sys_clk) if (ev === 1'b1) n_ev++;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // software pulse: 0 control, 1 status, 2 baud, 3 transmit, 4 rx read, 5 own address
  task automatic sw(input int n, input logic [15:0] x);
    @(posedge i_sys_clk);
    wdata   <= x;
    tx_d    <= x[7:0];
    ctl_wr  <= (n == 0);
    sta_wr  <= (n == 1);
    baud_wr <= (n == 2);
    tx_wr   <= (n == 3);
    rx_rd   <= (n == 4);
    if (n == 5) own <= x[9:0];
    @(posedge i_sys_clk);
    {ctl_wr, sta_wr, baud_wr, tx_wr, rx_rd} <= 5'h00;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  // let the ninth fall reach the flags, then compare ack and events
  task automatic after(input logic g, input logic e, input int inc);
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    exp_ev += inc;
    chk(16'(g), 16'(e));
    chk(16'(n_ev), 16'(exp_ev));
  endtask
  task automatic addr(input logic [7:0] b, input logic e, input int inc);
    u_m.write_byte(b, a);
    after(a, e, inc);
  endtask
  task automatic rx_byte(input logic [7:0] b);
    logic nk;
    nk = exp_rbf | exp_ov;
    if (exp_rbf) begin
      exp_ov = 1'b1;
    end else begin
      exp_buf = b;
      exp_rbf = 1'b1;
    end
    addr(b, nk, 1);
    chk(16'(rx_q), 16'(exp_buf));
    chk(16'(sta_q[STA_RXFULL]), 16'(exp_rbf));
    chk(16'(sta_q[STA_OV]), 16'(exp_ov));
  endtask
  // read phase: stretched until load and release, then one byte out
  task automatic tx_byte(input logic [15:0] c);
    chk(16'(scl_oe), 16'h0001);
    chk(16'(sta_q[STA_DIR]), 16'h0001);
    d = 8'($urandom);
    txq.push_back(d);
    sw(3, {8'h00, d});
    // single buffer: the byte has already moved into the shifter
    chk(16'(sta_q[STA_TXFULL]), 16'h0000);
    chk(16'(scl_oe), 16'h0001);
    sw(0, c);
    chk(16'(scl_oe), 16'h0000);
    u_m.read_byte(1'b1, rd);
    after(1'b0, 1'b0, 1);
    chk(16'(rd), 16'(txq.pop_front()));
    u_m.send_stop();
  endtask
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    n_fail++;
    print_verdict();
  end
  always @(posedge stuck) begin
    n_fail++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hf0b6));
    {i_reset, ctl_wr, sta_wr, tx_wr, rx_rd, baud_wr} = 6'h20;
    {wdata, own, tx_d} = '0;
    {exp_rbf, exp_ov, exp_buf, n_ev, exp_ev} = '0;
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(negedge i_sys_clk);
    chk(ctl_q, CTL_RESET);
    chk(sta_q, 16'h0000);
    sw(5, 16'($urandom) & 16'h007f);
    v = (16'($urandom) & 16'h6bbf) | 16'h9000;
    sw(0, v);
    chk(ctl_q, v);
    sw(2, 16'h0005);
    for (k = 0; k < 100 && tick !== 1'b1; k++) @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    for (k = 1; k < 100 && tick !== 1'b1; k++) @(negedge i_sys_clk);
    chk(16'(k), 16'h0006);
    // wrong address: no ack, no event
    u_m.send_start();
    addr({own[6:0] ^ 7'h01, 1'b0}, 1'b1, 0);
    u_m.send_stop();
    u_m.send_start();
    addr({own[6:0], 1'b0}, 1'b0, 1);
    chk(16'(sta_q[STA_RXFULL]), 16'h0000);
    rx_byte(8'($urandom));
    rx_byte(8'($urandom));
    sw(4, 16'h0000);
    exp_rbf = 1'b0;
    rx_byte(8'($urandom));
    u_m.send_stop();
    repeat (8) @(posedge i_sys_clk);
    chk(16'(sta_q[STA_ADDRD]), 16'h0000);
    old = sta_q;
    v = {7'($urandom), 9'h03f};
    sw(1, v);
    chk(16'(sta_q[15:6]), 16'(v[15:6]));
    chk(16'(sta_q[5:0]), 16'(old[5:0]));
    sw(4, 16'h0000);
    {exp_rbf, exp_ov} = 2'b00;
    u_m.send_start();
    addr({own[6:0], 1'b1}, 1'b0, 1);
    tx_byte(16'h9000);
    // ten-bit: refused read header, then full match, data, turnaround
    sw(5, 16'($urandom) & 16'h03ff);
    // receive stretch enabled for the wide-address pass
    sw(0, 16'h9440);
    u_m.send_start();
    addr({5'h1e, own[9:8], 1'b1}, 1'b1, 0);
    u_m.send_stop();
    u_m.send_start();
    addr({5'h1e, own[9:8], 1'b0}, 1'b0, 1);
    chk(16'(sta_q[STA_FWM]), 16'h0000);
    addr(own[7:0], 1'b0, 1);
    chk(16'(sta_q[STA_FWM]), 16'h0001);
    rx_byte(8'($urandom));
    // full buffer at the ninth clock holds the clock until released
    chk(16'(scl_oe), 16'h0001);
    sw(4, 16'h0000);
    exp_rbf = 1'b0;
    sw(0, 16'h9440);
    chk(16'(scl_oe), 16'h0000);
    u_m.send_start();
    addr({5'h1e, own[9:8], 1'b1}, 1'b0, 1);
    tx_byte(16'h9440);
    repeat (8) @(posedge i_sys_clk);
    chk(16'(sta_q[STA_FWM]), 16'h0000);
    print_verdict();
  end
endmodule
